// file: aspr_far_model.sv
// behavioural model of the audio processors on the primary and secondary ports
`timescale 1ns/1ps
module aspr_far_model (
    input wire logic run_i,
    input wire logic [10:0] pat_i,
    output logic [10:0] pins_o
);
    // link clock, stands still low outside frames
    logic link_clk = 1'h0;
    // frame counter feeding clock and data patterns
    logic [7:0] cnt = 8'h00;
    // 320 ns link clock, offset so its edges never meet the system clock edges
    initial begin
        #7;
        forever begin
            #160;
            link_clk = run_i ? ~link_clk : 1'h0;
        end
    end
    // data moves on the falling link edge, away from the edge a receiver samples
    always @(negedge link_clk) begin
        cnt <= cnt + 8'h01;
    end
    // in frames: clocks and data; between frames: a steady pattern from the bench
    always_comb begin
        if (run_i) begin
            pins_o = {cnt[0] ^ cnt[3], cnt[4], link_clk, cnt[7:0]};
        end else begin
            pins_o = pat_i;
        end
    end
endmodule

// file: aspr_pin_sel.sv
// eight-way pin selector that forces reserved codes low
`timescale 1ns/1ps
module aspr_pin_sel #(
    parameter logic [7:0] RSV_MASK = 8'h00
) (
    input wire logic [2:0] code_i,
    input wire logic [7:0] pins_i,
    output logic sel_o
);
    // reserved code gives a defined low instead of a floating pick
    always_comb begin
        if (RSV_MASK[code_i]) begin
            sel_o = 1'b0;
        end else begin
            sel_o = pins_i[code_i];
        end
    end
endmodule

// file: aspr_pkg.sv
// constants for the audio serial port routing block
package aspr_pkg;
    // register word indices; byte address is four times the index
    localparam logic [7:0] ASPR_IDX_SRC_SEL = 8'h1f;
    localparam logic [7:0] ASPR_IDX_IN_SEL = 8'h20;
    localparam logic [7:0] ASPR_IDX_OUT_SEL = 8'h21;
    localparam logic [7:0] ASPR_IDX_STATUS = 8'h3f;
    // reset values
    localparam logic [7:0] ASPR_RST_SRC_SEL = 8'h00;
    localparam logic [7:0] ASPR_RST_IN_SEL = 8'h00;
    localparam logic [7:0] ASPR_RST_OUT_SEL = 8'h00;
    // source select register fields
    localparam int ASPR_SRC_SBCLK_LSB = 5;
    localparam int ASPR_SRC_SFCLK_LSB = 2;
    localparam int ASPR_SRC_SERIAL_DATA_IN_LSB = 0;
    // input select register fields
    localparam int ASPR_IN_REC_LSB = 5;
    localparam int ASPR_IN_BCLK_BIT = 3;
    localparam int ASPR_IN_FCLK_BIT = 2;
    localparam int ASPR_IN_REC_BIT = 1;
    localparam int ASPR_IN_DIN_BIT = 0;
    // output select register fields
    localparam int ASPR_OUT_PBCLK_BIT = 7;
    localparam int ASPR_OUT_SBCLK_BIT = 6;
    localparam int ASPR_OUT_PFCLK_LSB = 4;
    localparam int ASPR_OUT_SFCLK_LSB = 2;
    localparam int ASPR_OUT_PDOUT_BIT = 1;
    localparam int ASPR_OUT_SERIAL_DATA_OUT_BIT = 0;
    // reserved pin codes per 3-bit source field (bit n set: code n reserved)
    localparam logic [7:0] ASPR_RSV_REC_SRC = 8'h08;
    localparam logic [7:0] ASPR_RSV_NONE = 8'h00;
    // frame-clock output codes
    localparam logic [1:0] ASPR_FO_CODE_0 = 2'h0;
    localparam logic [1:0] ASPR_FO_CODE_1 = 2'h1;
    localparam logic [1:0] ASPR_FO_CODE_2 = 2'h2;
    // pin vector positions
    localparam int ASPR_PIN_GENERAL_IO_PIN_1 = 0;
    localparam int ASPR_PIN_SPI_CLK = 1;
    localparam int ASPR_PIN_GENERAL_IO_PIN_2 = 4;
    localparam int ASPR_PIN_IN1 = 5;
endpackage

// file: aspr_sync.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module aspr_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg; // first stage, read only by second stage

    // two stages, nothing else reads the first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule

// file: aspr_top.sv
// audio serial port routing: register slave, pin selection, output routing
// Contract
// - record frame clock pin from 3-bit field
// - bit-clock select feeds interface and clock generator
// - frame-clock select feeds serial interface
// - record clock: playback clock or routed
// - data-input select feeds serial interface
// - primary bit-clock out: internal or secondary
// - secondary bit-clock out: primary or internal
// - primary frame-clock out 2-bit select
// - secondary frame-clock out 2-bit select
// - primary data out: codec or secondary input
// - secondary data out: primary input or codec
// - secondary bit clock pin from 3-bit field
// - secondary frame clock pin, same encoding
// - secondary data input pin from 2-bit field
`timescale 1ns/1ps
module aspr_top #(
    parameter int ADR_W = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // device pins, asynchronous
    input wire logic general_io_pin_1_i,
    input wire logic general_io_pin_2_i,
    input wire logic spi_clk_pin_i,
    input wire logic spi_data_out_pin_i,
    input wire logic serial_data_out_pin_i,
    input wire logic input_pin_1_i,
    input wire logic input_pin_2_i,
    input wire logic input_pin_3_i,
    input wire logic pri_bit_clk_i,
    input wire logic pri_frame_clk_i,
    input wire logic pri_serial_data_in_i,
    // internal codec sources, same clock
    input wire logic int_bit_clk_i,
    input wire logic playback_sample_rate_clock_i,
    input wire logic record_sample_rate_clock_i,
    input wire logic codec_serial_data_out_i,
    // feeds to serial interface and clock generator
    output logic si_bit_clk_o,
    output logic clock_generator_block_bit_clk_o,
    output logic si_frame_clk_o,
    output logic si_rec_frame_clk_o,
    output logic si_serial_data_in_o,
    // pin outputs
    output logic pri_bit_clk_o,
    output logic sec_bit_clk_o,
    output logic pri_frame_clk_o,
    output logic sec_frame_clk_o,
    output logic pri_serial_data_out_o,
    output logic sec_serial_data_out_o
);
    // configuration registers
    logic [7:0] src_sel_reg; // secondary source pin selection
    logic [7:0] in_sel_reg; // secondary_port_input_select
    logic [7:0] out_sel_reg; // secondary_port_output_select
    logic ack_reg; // bus acknowledge
    logic [31:0] rdat_reg; // bus read data
    // synchronised pins
    logic [7:0] pins_raw; // shared pin vector before sync
    logic [7:0] pins_s; // shared pin vector after sync
    logic [2:0] pri_s; // primary bit clock, frame clock, data in
    // routing results
    logic sec_bclk; // selected secondary bit clock
    logic sec_fclk; // selected secondary frame clock
    logic rec_fclk; // selected record frame clock
    logic sec_din; // selected secondary data in
    logic si_bclk_next;
    logic si_fclk_next;
    logic si_rec_next;
    logic si_din_next;
    logic pri_bclk_next;
    logic sec_bclk_next;
    logic pri_fclk_next;
    logic sec_fclk_next;
    logic pri_dout_next;
    logic sec_dout_next;
    // bus decode
    logic bus_req; // live request not yet answered

    // true when the byte address is word aligned and hits the index
    function automatic logic idx_hit(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
        idx_hit = (adr[ADR_W-1:2] == (ADR_W-2)'(idx)) && (adr[1:0] == 2'h0);
    endfunction

    // frame-clock output select; reserved code gives low
    function automatic logic fo_pick(input logic [1:0] code, input logic a,
                                     input logic b, input logic c);
        case (code)
            aspr_pkg::ASPR_FO_CODE_0: fo_pick = a;
            aspr_pkg::ASPR_FO_CODE_1: fo_pick = b;
            aspr_pkg::ASPR_FO_CODE_2: fo_pick = c;
            default: fo_pick = 1'b0;
        endcase
    endfunction

    assign bus_req = cyc_i && stb_i && !ack_reg;
    assign ack_o = ack_reg;
    assign dat_o = rdat_reg;

    // pin vector in source-code order
    assign pins_raw = {input_pin_3_i, input_pin_2_i, input_pin_1_i, general_io_pin_2_i,
                       serial_data_out_pin_i, spi_data_out_pin_i, spi_clk_pin_i,
                       general_io_pin_1_i};

    // pins cross into the register clock through two flops
    aspr_sync #(
        .W(8)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    // primary port inputs cross the same way
    aspr_sync #(
        .W(3)
    ) u_pri_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({pri_bit_clk_i, pri_frame_clk_i, pri_serial_data_in_i}),
        .q_o(pri_s)
    );

    // secondary bit clock source pin
    aspr_pin_sel #(
        .RSV_MASK(aspr_pkg::ASPR_RSV_NONE)
    ) u_sbclk_sel (
        .code_i(src_sel_reg[aspr_pkg::ASPR_SRC_SBCLK_LSB +: 3]),
        .pins_i(pins_s),
        .sel_o(sec_bclk)
    );

    // secondary frame clock source pin, same encoding
    aspr_pin_sel #(
        .RSV_MASK(aspr_pkg::ASPR_RSV_NONE)
    ) u_sfclk_sel (
        .code_i(src_sel_reg[aspr_pkg::ASPR_SRC_SFCLK_LSB +: 3]),
        .pins_i(pins_s),
        .sel_o(sec_fclk)
    );

    // record frame clock source pin; data-out pin code reserved
    aspr_pin_sel #(
        .RSV_MASK(aspr_pkg::ASPR_RSV_REC_SRC)
    ) u_rec_sel (
        .code_i(in_sel_reg[aspr_pkg::ASPR_IN_REC_LSB +: 3]),
        .pins_i(pins_s),
        .sel_o(rec_fclk)
    );

    // secondary data input from a 2-bit pin field
    always_comb begin
        case (src_sel_reg[aspr_pkg::ASPR_SRC_SERIAL_DATA_IN_LSB +: 2])
            2'h0: sec_din = pins_s[aspr_pkg::ASPR_PIN_GENERAL_IO_PIN_1];
            2'h1: sec_din = pins_s[aspr_pkg::ASPR_PIN_SPI_CLK];
            2'h2: sec_din = pins_s[aspr_pkg::ASPR_PIN_GENERAL_IO_PIN_2];
            default: sec_din = pins_s[aspr_pkg::ASPR_PIN_IN1];
        endcase
    end

    // feeds toward the codec serial interface
    always_comb begin
        // bit clock chosen once, shared by interface and clock generator
        si_bclk_next = in_sel_reg[aspr_pkg::ASPR_IN_BCLK_BIT] ? sec_bclk : pri_s[2];
        si_fclk_next = in_sel_reg[aspr_pkg::ASPR_IN_FCLK_BIT] ? sec_fclk : pri_s[1];
        // record frame clock follows the playback frame clock unless split
        si_rec_next = in_sel_reg[aspr_pkg::ASPR_IN_REC_BIT] ? rec_fclk : si_fclk_next;
        si_din_next = in_sel_reg[aspr_pkg::ASPR_IN_DIN_BIT] ? sec_din : pri_s[0];
    end

    // drives toward the primary and secondary port pins
    always_comb begin
        pri_bclk_next = out_sel_reg[aspr_pkg::ASPR_OUT_PBCLK_BIT] ? sec_bclk
                                                                  : int_bit_clk_i;
        sec_bclk_next = out_sel_reg[aspr_pkg::ASPR_OUT_SBCLK_BIT] ? int_bit_clk_i
                                                                  : pri_s[2];
        pri_fclk_next = fo_pick(out_sel_reg[aspr_pkg::ASPR_OUT_PFCLK_LSB +: 2],
                                playback_sample_rate_clock_i,
                                record_sample_rate_clock_i, sec_fclk);
        sec_fclk_next = fo_pick(out_sel_reg[aspr_pkg::ASPR_OUT_SFCLK_LSB +: 2], pri_s[1],
                                playback_sample_rate_clock_i,
                                record_sample_rate_clock_i);
        pri_dout_next = out_sel_reg[aspr_pkg::ASPR_OUT_PDOUT_BIT] ? sec_din
            : codec_serial_data_out_i;
        sec_dout_next = out_sel_reg[aspr_pkg::ASPR_OUT_SERIAL_DATA_OUT_BIT] ? codec_serial_data_out_i
                                                                  : pri_s[0];
    end

    // every routed signal leaves through a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            si_bit_clk_o <= 1'b0;
            clock_generator_block_bit_clk_o <= 1'b0;
            si_frame_clk_o <= 1'b0;
            si_rec_frame_clk_o <= 1'b0;
            si_serial_data_in_o <= 1'b0;
            pri_bit_clk_o <= 1'b0;
            sec_bit_clk_o <= 1'b0;
            pri_frame_clk_o <= 1'b0;
            sec_frame_clk_o <= 1'b0;
            pri_serial_data_out_o <= 1'b0;
            sec_serial_data_out_o <= 1'b0;
        end else begin
            si_bit_clk_o <= si_bclk_next;
            clock_generator_block_bit_clk_o <= si_bclk_next;
            si_frame_clk_o <= si_fclk_next;
            si_rec_frame_clk_o <= si_rec_next;
            si_serial_data_in_o <= si_din_next;
            pri_bit_clk_o <= pri_bclk_next;
            sec_bit_clk_o <= sec_bclk_next;
            pri_frame_clk_o <= pri_fclk_next;
            sec_frame_clk_o <= sec_fclk_next;
            pri_serial_data_out_o <= pri_dout_next;
            sec_serial_data_out_o <= sec_dout_next;
        end
    end

    // register writes: low byte lane only, stored as the answer is raised
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_sel_reg <= aspr_pkg::ASPR_RST_SRC_SEL;
            in_sel_reg <= aspr_pkg::ASPR_RST_IN_SEL;
            out_sel_reg <= aspr_pkg::ASPR_RST_OUT_SEL;
        end else if (bus_req && we_i && sel_i[0]) begin
            if (idx_hit(adr_i, aspr_pkg::ASPR_IDX_SRC_SEL)) begin
                src_sel_reg <= dat_i[7:0];
            end
            if (idx_hit(adr_i, aspr_pkg::ASPR_IDX_IN_SEL)) begin
                in_sel_reg <= dat_i[7:0];
            end
            if (idx_hit(adr_i, aspr_pkg::ASPR_IDX_OUT_SEL)) begin
                out_sel_reg <= dat_i[7:0];
            end
        end
    end

    // acknowledge every request, mapped or not, one cycle later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    // read data; unmapped words and upper bits read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_reg <= 32'h0000_0000;
        end else if (bus_req && !we_i) begin
            if (idx_hit(adr_i, aspr_pkg::ASPR_IDX_SRC_SEL)) begin
                rdat_reg <= {24'h00_0000, src_sel_reg};
            end else if (idx_hit(adr_i, aspr_pkg::ASPR_IDX_IN_SEL)) begin
                rdat_reg <= {24'h00_0000, in_sel_reg};
            end else if (idx_hit(adr_i, aspr_pkg::ASPR_IDX_OUT_SEL)) begin
                rdat_reg <= {24'h00_0000, out_sel_reg};
            end else if (idx_hit(adr_i, aspr_pkg::ASPR_IDX_STATUS)) begin
                // live levels of the routed signals, without the two frame-clock outputs and the clock-generator copy
                rdat_reg <= {24'h00_0000, si_bit_clk_o, si_frame_clk_o, si_rec_frame_clk_o,
                             si_serial_data_in_o, pri_bit_clk_o, sec_bit_clk_o,
                             pri_serial_data_out_o, sec_serial_data_out_o};
            end else begin
                rdat_reg <= 32'h0000_0000;
            end
        end
    end

    // checks on routing and bus timing
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_rec_src_general_io_pin_1: assert property (
        (in_sel_reg[7:5] == 3'h0 && in_sel_reg[1])[*4]
        |-> si_rec_frame_clk_o == $past(general_io_pin_1_i, 3)
    ) else $error("record frame clock not from general io pin 1");

    a_bclk_pair_same: assert property (
        si_bit_clk_o == clock_generator_block_bit_clk_o
    ) else $error("interface and clock generator bit clocks differ");

    a_si_bclk_pri: assert property (
        (!in_sel_reg[3])[*4] |-> si_bit_clk_o == $past(pri_bit_clk_i, 3)
    ) else $error("primary bit clock not fed to interface");

    a_si_fclk_pri: assert property (
        (!in_sel_reg[2])[*4] |-> si_frame_clk_o == $past(pri_frame_clk_i, 3)
    ) else $error("primary frame clock not fed to interface");

    a_rec_follow_play: assert property (
        !in_sel_reg[1] |=> si_rec_frame_clk_o == si_frame_clk_o
    ) else $error("record frame clock does not follow playback");

    a_si_din_pri: assert property (
        (!in_sel_reg[0])[*4] |-> si_serial_data_in_o == $past(pri_serial_data_in_i, 3)
    ) else $error("primary data not fed to interface");

    a_pri_bclk_int: assert property (
        !out_sel_reg[7] |=> pri_bit_clk_o == $past(int_bit_clk_i)
    ) else $error("primary bit clock output not internal");

    a_sec_bclk_loop: assert property (
        (!out_sel_reg[6])[*4] |-> sec_bit_clk_o == $past(pri_bit_clk_i, 3)
    ) else $error("secondary bit clock output not primary loop");

    a_pri_fclk_rec: assert property (
        out_sel_reg[5:4] == 2'h1 |=> pri_frame_clk_o == $past(record_sample_rate_clock_i)
    ) else $error("primary frame clock output not record rate");

    a_fclk_rsv_low: assert property (
        out_sel_reg[5:4] == 2'h3 || out_sel_reg[3:2] == 2'h3
        |=> (pri_frame_clk_o == 1'b0 || $past(out_sel_reg[5:4]) != 2'h3)
            && (sec_frame_clk_o == 1'b0 || $past(out_sel_reg[3:2]) != 2'h3)
    ) else $error("reserved frame clock code not driven low");

    a_sec_fclk_play: assert property (
        out_sel_reg[3:2] == 2'h1 |=> sec_frame_clk_o == $past(playback_sample_rate_clock_i)
    ) else $error("secondary frame clock output not playback rate");

    a_pri_dout_codec: assert property (
        !out_sel_reg[1] |=> pri_serial_data_out_o == $past(codec_serial_data_out_i)
    ) else $error("primary data output not codec");

    a_sec_dout_codec: assert property (
        out_sel_reg[0] |=> sec_serial_data_out_o == $past(codec_serial_data_out_i)
    ) else $error("secondary data output not codec");

    a_serial_data_in_in1_pick: assert property (
        (src_sel_reg[1:0] == 2'h3 && in_sel_reg[0])[*4]
        |-> si_serial_data_in_o == $past(input_pin_1_i, 3)
    ) else $error("secondary data input not from input pin 1");

    a_ack_one_cycle: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o
    ) else $error("bus answer not a one-cycle pulse after request");
endmodule

// file: aspr_top_tb.sv
// self-checking bench for the audio serial port routing block
`timescale 1ns/1ps
module aspr_top_tb;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    // wishbone master side
    logic cyc_i = 1'h0;
    logic stb_i = 1'h0;
    logic we_i = 1'h0;
    logic [9:0] adr_i = 10'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    // internal sources: bit clock, playback rate, record rate, codec data
    logic [3:0] int_src = 4'h0;
    // far side control and pins
    logic run = 1'h0;
    logic [10:0] pat = 11'h000;
    logic [10:0] pins;
    // routed outputs, see exp_route for the bit order
    logic [10:0] dout;
    logic [31:0] seed = 32'h7e770a2c;
    logic [31:0] rd;
    logic [7:0] src_v;
    logic [7:0] in_v;
    logic [7:0] out_v;
    // pin levels at the last three edges, newest in the low bits
    logic [32:0] p_h;
    // internal sources as sampled at the last edge
    logic [3:0] q_h;
    // expected routed outputs during live frames
    logic [10:0] e_v;
    int n_mismatch = 0;
    int n_tests = 0;
    // clock at 25 MHz
    always #20 clk_i = ~clk_i;
    aspr_far_model u_far (.run_i(run), .pat_i(pat), .pins_o(pins));
    aspr_top #(.ADR_W(10)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .general_io_pin_1_i(pins[0]), .spi_clk_pin_i(pins[1]), .spi_data_out_pin_i(pins[2]),
        .serial_data_out_pin_i(pins[3]), .general_io_pin_2_i(pins[4]),
        .input_pin_1_i(pins[5]), .input_pin_2_i(pins[6]), .input_pin_3_i(pins[7]),
        .pri_bit_clk_i(pins[8]), .pri_frame_clk_i(pins[9]), .pri_serial_data_in_i(pins[10]),
        .int_bit_clk_i(int_src[0]), .playback_sample_rate_clock_i(int_src[1]),
        .record_sample_rate_clock_i(int_src[2]), .codec_serial_data_out_i(int_src[3]),
        .si_bit_clk_o(dout[10]), .clock_generator_block_bit_clk_o(dout[9]),
        .si_frame_clk_o(dout[8]), .si_rec_frame_clk_o(dout[7]), .si_serial_data_in_o(dout[6]),
        .pri_bit_clk_o(dout[5]), .sec_bit_clk_o(dout[4]), .pri_frame_clk_o(dout[3]),
        .sec_frame_clk_o(dout[2]), .pri_serial_data_out_o(dout[1]),
        .sec_serial_data_out_o(dout[0]));
    // xorshift step for repeatable random values
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    // expected routed outputs from register values, pin levels and internal sources
    function automatic logic [10:0] exp_route(input logic [7:0] s, input logic [7:0] i,
            input logic [7:0] o, input logic [10:0] p, input logic [3:0] q);
        logic sb;
        logic sf;
        logic sd;
        logic rp;
        logic [3:0] d2;
        logic [10:0] e;
        sb = p[s[7:5]];
        sf = p[s[4:2]];
        d2 = {p[5], p[4], p[1], p[0]};
        sd = d2[s[1:0]];
        rp = (i[7:5] == 3'h3) ? 1'h0 : p[i[7:5]];
        e[10] = i[3] ? sb : p[8];
        e[9] = e[10];
        e[8] = i[2] ? sf : p[9];
        e[7] = i[1] ? rp : e[8];
        e[6] = i[0] ? sd : p[10];
        e[5] = o[7] ? sb : q[0];
        e[4] = o[6] ? q[0] : p[8];
        e[3] = (o[5:4] == 2'h0) ? q[1] : (o[5:4] == 2'h1) ? q[2] : (o[5:4] == 2'h2) ? sf : 1'h0;
        e[2] = (o[3:2] == 2'h0) ? p[9] : (o[3:2] == 2'h1) ? q[1] : (o[3:2] == 2'h2) ? q[2] : 1'h0;
        e[1] = o[1] ? sd : q[3];
        e[0] = o[0] ? q[3] : p[10];
        return e;
    endfunction
    // one comparison, counted
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic wishbone cycle; answer is taken at the edge where ack is high
    task automatic wb(input logic w, input logic [7:0] idx, input logic [3:0] s,
            input logic [7:0] wd, output logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= {idx, 2'h0};
        sel_i <= s;
        dat_i <= {24'h0, wd};
        // levels read right at an edge are those that edge samples
        @(posedge clk_i);
        while (ack_o !== 1'h1) begin
            @(posedge clk_i);
        end
        d = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        we_i <= 1'h0;
    endtask
    // program all three routing registers, read one back
    task automatic apply(input logic [7:0] s, input logic [7:0] i, input logic [7:0] o);
        src_v = s;
        in_v = i;
        out_v = o;
        wb(1'h1, aspr_pkg::ASPR_IDX_SRC_SEL, 4'h1, s, rd);
        wb(1'h1, aspr_pkg::ASPR_IDX_IN_SEL, 4'h1, i, rd);
        wb(1'h1, aspr_pkg::ASPR_IDX_OUT_SEL, 4'h1, o, rd);
        wb(1'h0, aspr_pkg::ASPR_IDX_IN_SEL, 4'h1, 8'h00, rd);
        check(rd, {24'h0, i});
    endtask
    // let pins pass the synchronisers, then compare every routed output and status
    task automatic route_check();
        logic [10:0] e;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        e = exp_route(src_v, in_v, out_v, pat, int_src);
        check(dout[10], e[10]);
        check(dout[9], e[9]);
        check(dout[8], e[8]);
        check(dout[7], e[7]);
        check(dout[6], e[6]);
        check(dout[5], e[5]);
        check(dout[4], e[4]);
        check(dout[3], e[3]);
        check(dout[2], e[2]);
        check(dout[1], e[1]);
        check(dout[0], e[0]);
        wb(1'h0, aspr_pkg::ASPR_IDX_STATUS, 4'h1, 8'h00, rd);
        check(rd, {24'h0, e[10], e[8:4], e[1:0]});
    endtask
    // fresh random pin pattern and internal sources
    task automatic shuffle();
        seed = xs(seed);
        pat <= seed[10:0];
        int_src <= seed[14:11];
    endtask
    // verdict and end of run
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #400000;
        n_mismatch++;
        $display("BAD %0t timeout", $time);
        complete_run();
    end
    // main sequence
    initial begin
        logic [2:0] c;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        // reset values of the routing registers
        wb(1'h0, aspr_pkg::ASPR_IDX_SRC_SEL, 4'h1, 8'h00, rd);
        check(rd, {24'h0, aspr_pkg::ASPR_RST_SRC_SEL});
        wb(1'h0, aspr_pkg::ASPR_IDX_OUT_SEL, 4'h1, 8'h00, rd);
        check(rd, {24'h0, aspr_pkg::ASPR_RST_OUT_SEL});
        // unmapped place reads zero, masked byte lane is not written
        wb(1'h1, 8'h22, 4'h1, 8'ha5, rd);
        wb(1'h0, 8'h22, 4'h1, 8'h00, rd);
        check(rd, 32'h0);
        wb(1'h1, aspr_pkg::ASPR_IDX_IN_SEL, 4'h0, 8'hff, rd);
        wb(1'h0, aspr_pkg::ASPR_IDX_IN_SEL, 4'h1, 8'h00, rd);
        check(rd, {24'h0, aspr_pkg::ASPR_RST_IN_SEL});
        // every pin code in every field, reserved ones included
        for (int k = 0; k < 8; k++) begin
            c = k[2:0];
            shuffle();
            // secondary sources fed inward so every pin code reaches an output, the record field at odd codes only
            apply({c, c, c[1:0]}, {c, seed[19], 2'h3, c[0], 1'h1},
                  {seed[23:22], c[1:0], c[1:0], seed[21:20]});
            route_check();
        end
        // random configurations
        repeat (40) begin
            shuffle();
            apply(seed[31:24], seed[23:16], seed[22:15]);
            route_check();
        end
        // reset in mid-run clears every output, the read data and the output select register
        @(posedge clk_i);
        rst_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        check(dout, 11'h000);
        check(dat_o, 32'h0);
        @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h0, aspr_pkg::ASPR_IDX_OUT_SEL, 4'h1, 8'h00, rd);
        check(rd, {24'h0, aspr_pkg::ASPR_RST_OUT_SEL});
        // live frames: pins show two edges late, internal sources at the edge
        apply(8'h15, 8'h0d, 8'h9b);
        p_h = {pat, pat, pat};
        run <= 1'h1;
        repeat (600) begin
            @(posedge clk_i);
            q_h = int_src;
            p_h = {p_h[21:0], pins};
            seed = xs(seed);
            int_src <= seed[3:0];
            @(negedge clk_i);
            check(dout[9], dout[10]);
            e_v = exp_route(src_v, in_v, out_v, p_h[32:22], q_h);
            check(dout, e_v);
        end
        @(posedge clk_i);
        run <= 1'h0;
        shuffle();
        route_check();
        complete_run();
    end
endmodule
